// [design/dcd_pkg.sv]
package dcd_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DCD_CMD_NONE   = 5'h00,
    DCD_CMD_MRS    = 5'h01,
    DCD_CMD_REF    = 5'h02,
    DCD_CMD_SRE    = 5'h03,
    DCD_CMD_SRX    = 5'h04,
    DCD_CMD_PRE    = 5'h05,
    DCD_CMD_PREA   = 5'h06,
    DCD_CMD_ACT    = 5'h07,
    DCD_CMD_WR     = 5'h08,
    DCD_CMD_WRA    = 5'h09,
    DCD_CMD_RD     = 5'h0A,
    DCD_CMD_RDA    = 5'h0B,
    DCD_CMD_NOP    = 5'h0C,
    DCD_CMD_DES    = 5'h0D,
    DCD_CMD_PDE    = 5'h0E,
    DCD_CMD_PDX    = 5'h0F,
    DCD_CMD_ZQCL   = 5'h10,
    DCD_CMD_ZQCS   = 5'h11,
    DCD_CMD_ILLEGL = 5'h12
  } dcd_cmd_type;

  // ----------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------
  localparam int          DCD_ADDR_W     = 14;
  localparam int          DCD_A10_BIT    = 10;
  localparam int          DCD_A12_BIT    = 12;
  localparam int          DCD_VREF_LO    = 0;
  localparam int          DCD_VREF_HI    = 5;
  localparam int          DCD_VRANGE_BIT = 6;
  localparam int          DCD_VTRAIN_BIT = 7;
  localparam int          DCD_BL_LO      = 0;
  localparam int          DCD_BL_HI      = 1;
  localparam logic [1:0]  DCD_BL_FIX8    = 2'h0;
  localparam logic [1:0]  DCD_BL_OTF     = 2'h1;
  localparam logic [1:0]  DCD_BL_FIX4    = 2'h2;
  localparam logic [2:0]  DCD_MR_RCW     = 3'h7;
  localparam logic [2:0]  DCD_MR_SEVEN   = 3'h7;
  localparam logic [2:0]  DCD_MR_ZERO    = 3'h0;
  localparam logic [2:0]  DCD_MR_SIX     = 3'h6;
  localparam logic [5:0]  DCD_VREF_MAX   = 6'h31;
  localparam logic [3:0]  DCD_BEATS_BL8  = 4'h8;
  localparam logic [3:0]  DCD_BEATS_BC4  = 4'h4;
  // Level in hundredths of a percent of the output supply
  localparam logic [13:0] DCD_R1_BASE    = 14'h1770;
  localparam logic [13:0] DCD_R2_BASE    = 14'h1194;
  localparam logic [13:0] DCD_STEP       = 14'h0041;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  cs_n;
    logic                  act_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic                  cke;
    logic                  odt;
    logic [1:0]            bg;
    logic [1:0]            ba;
    logic [DCD_ADDR_W-1:0] addr;
  } dcd_pins_type;

  typedef struct packed {
    dcd_cmd_type           cmd;
    logic                  valid;
    logic                  illegal;
    logic [1:0]            bg;
    logic [1:0]            ba;
    logic [16:0]           row;
    logic [9:0]            col;
    logic                  auto_pre;
    logic [3:0]            beats;
  } dcd_dec_type;

endpackage

// [design/dcd_sync.sv]
`timescale 1ns/10ps
module dcd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } dcd_sync_state_type;

  dcd_sync_state_type state_reg;
  dcd_sync_state_type state_next;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_comb begin
    state_next      = state_reg;
    state_next.meta = i_async;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.sync;
endmodule

// [design/dcd_vref.sv]
`timescale 1ns/10ps
module dcd_vref (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_load,
  input  wire logic [6:0]  i_value,
  output logic      [13:0] o_level,
  output logic             o_range
);
  import dcd_pkg::*;

  typedef struct packed {
    logic [13:0] level;
    logic        range;
  } dcd_vref_state_type;

  dcd_vref_state_type state_reg;
  dcd_vref_state_type state_next;
  logic [5:0]         step_sat;
  logic [13:0]        base;

  // ----------------------------------------------------------------
  // Reference level computation
  // ----------------------------------------------------------------
  // Steps above the last setting are clamped rather than wrapped
  always_comb begin
    state_next = state_reg;
    step_sat   = (i_value[DCD_VREF_HI:DCD_VREF_LO] > DCD_VREF_MAX) ?
                 DCD_VREF_MAX : i_value[DCD_VREF_HI:DCD_VREF_LO];
    base       = i_value[DCD_VRANGE_BIT] ? DCD_R2_BASE : DCD_R1_BASE;
    if (i_load) begin
      state_next.range = i_value[DCD_VRANGE_BIT];
      state_next.level = 14'(base + 14'(step_sat) * DCD_STEP);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= '{level: DCD_R1_BASE, range: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.level;
  assign o_range = state_reg.range;
endmodule

// [design/dcd_decoder.sv]
`timescale 1ns/10ps
// Contract
// - Decode command from CS, ACT, RAS, CAS, WE, CKE at rising edge.
// - ACT high uses shared pins as RAS/CAS/WE; low as A16..A14.
// - MRS selects the target mode register by bank group and bank bits.
// - Bank commands carry bank group and bank to select target bank.
// - CS low, ACT high, RAS low, CAS and WE high is reserved.
// - Calibration uses A10: high runs long, low runs short.
// - A started read or write burst always completes, never interrupted.
// - On-the-fly mode: A12 low gives chop of four, high gives eight.
// - No internal refresh activity while in power-down.
// - Termination level never alters decoding; termination off in self refresh.
// - Range one spans sixty to ninety-two percent of output supply.
// - Range two spans forty-five to seventy-seven percent of output supply.
// - Fifty settings per range, each step 0.65 percent.
// - Mode register seven writes are ignored entirely.
// - Mode writes with BG0 and bank bits 111 are ignored silently.
// - CS high takes no command; ongoing operations continue.
module dcd_decoder (
  input  wire logic                 i_clock,
  input  wire logic                 i_srst,
  input  wire dcd_pkg::dcd_pins_type i_pins,
  output dcd_pkg::dcd_dec_type      o_dec,
  output logic [2:0]                o_mr_sel,
  output logic [13:0]               o_mr_opcode,
  output logic                      o_mr_we,
  output logic [1:0]                o_bl_mode,
  output logic                      o_burst_busy,
  output logic                      o_zq_long,
  output logic                      o_zq_short,
  output logic                      o_refresh,
  output logic                      o_self_refresh,
  output logic                      o_power_down,
  output logic                      o_odt_active,
  output logic                      o_vref_train,
  output logic                      o_vref_range,
  output logic [13:0]               o_vref_level
);
  import dcd_pkg::*;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_DOWN   = 3'b010,
    PWR_SELF   = 3'b100
  } dcd_pwr_type;

  typedef struct packed {
    dcd_pwr_type  pwr;
    logic         cke_prev;
    dcd_dec_type  dec;
    logic [2:0]   mr_sel;
    logic [13:0]  mr_opcode;
    logic         mr_we;
    logic [1:0]   bl_mode;
    logic [3:0]   burst_left;
    logic         burst_busy;
    logic         in_self;
    logic         in_pdn;
    logic         zq_long;
    logic         zq_short;
    logic         refresh;
    logic         odt_active;
    logic         vref_train;
    logic         vref_load;
    logic [6:0]   vref_value;
  } dcd_state_type;

  dcd_state_type state_reg;
  dcd_state_type state_next;
  dcd_pins_type  pins;
  logic [$bits(dcd_pins_type)-1:0] pins_raw;
  dcd_dec_type   dec;
  logic [13:0]   vref_level;
  logic          vref_range;

  // ----------------------------------------------------------------
  // Pin synchronisation and reference generator
  // ----------------------------------------------------------------
  // Every pin passes two flops before decoding
  dcd_sync #(
    .WIDTH ($bits(dcd_pins_type))
  ) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_async (i_pins),
    .o_sync  (pins_raw)
  );
  assign pins = dcd_pins_type'(pins_raw);

  dcd_vref u_vref (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_load  (state_reg.vref_load),
    .i_value (state_reg.vref_value),
    .o_level (vref_level),
    .o_range (vref_range)
  );

  // ----------------------------------------------------------------
  // Burst beat count for a read or write
  // ----------------------------------------------------------------
  function automatic logic [3:0] beats_of(input logic [1:0] mode, input logic a12);
    unique case (mode)
      DCD_BL_OTF:  beats_of = a12 ? DCD_BEATS_BL8 : DCD_BEATS_BC4;
      DCD_BL_FIX4: beats_of = DCD_BEATS_BC4;
      default:     beats_of = DCD_BEATS_BL8;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Command table lookup
  // ----------------------------------------------------------------
  // ODT is deliberately absent from this decode
  always_comb begin
    dec          = '0;
    dec.cmd      = DCD_CMD_NONE;
    dec.bg       = pins.bg;
    dec.ba       = pins.ba;
    dec.col      = pins.addr[9:0];
    dec.auto_pre = pins.addr[DCD_A10_BIT];
    dec.row      = {pins.ras_n, pins.cas_n, pins.we_n, pins.addr};
    dec.beats    = beats_of(state_reg.bl_mode, pins.addr[DCD_A12_BIT]);
    dec.valid    = 1'b1;
    if (state_reg.cke_prev && pins.cke) begin
      if (pins.cs_n) begin
        dec.cmd = DCD_CMD_DES;
      end else if (!pins.act_n) begin
        dec.cmd = DCD_CMD_ACT;
      end else begin
        unique case ({pins.ras_n, pins.cas_n, pins.we_n})
          3'b000: dec.cmd = DCD_CMD_MRS;
          3'b001: dec.cmd = DCD_CMD_REF;
          3'b010: dec.cmd = pins.addr[DCD_A10_BIT] ? DCD_CMD_PREA : DCD_CMD_PRE;
          3'b011: dec.cmd = DCD_CMD_ILLEGL;
          3'b100: dec.cmd = pins.addr[DCD_A10_BIT] ? DCD_CMD_WRA : DCD_CMD_WR;
          3'b101: dec.cmd = pins.addr[DCD_A10_BIT] ? DCD_CMD_RDA : DCD_CMD_RD;
          3'b110: dec.cmd = pins.addr[DCD_A10_BIT] ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
          default: dec.cmd = DCD_CMD_NOP;
        endcase
      end
    end else if (state_reg.cke_prev && !pins.cke) begin
      if (pins.cs_n || (!pins.act_n ? 1'b0 : &{pins.ras_n, pins.cas_n, pins.we_n})) begin
        dec.cmd = DCD_CMD_PDE;
      end else if (!pins.act_n || {pins.ras_n, pins.cas_n, pins.we_n} != 3'b001) begin
        dec.cmd = DCD_CMD_ILLEGL;
      end else begin
        dec.cmd = DCD_CMD_SRE;
      end
    end else if (!state_reg.cke_prev && pins.cke) begin
      if (pins.cs_n || (pins.act_n && &{pins.ras_n, pins.cas_n, pins.we_n})) begin
        dec.cmd = (state_reg.pwr == PWR_SELF) ? DCD_CMD_SRX : DCD_CMD_PDX;
      end else begin
        dec.cmd = DCD_CMD_ILLEGL;
      end
    end else begin
      dec.valid = 1'b0;                                                 // CKE low held
    end
    // Anything that matches no table row is flagged
    dec.illegal = (dec.cmd == DCD_CMD_ILLEGL);
    if (dec.illegal) begin
      dec.valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.cke_prev   = pins.cke;
    state_next.dec        = dec;
    state_next.mr_we      = 1'b0;
    state_next.zq_long    = 1'b0;
    state_next.zq_short   = 1'b0;
    state_next.refresh    = 1'b0;
    state_next.vref_load  = 1'b0;
    // Burst runs to the end regardless of what arrives meanwhile
    if (state_reg.burst_left != 4'h0) begin
      state_next.burst_left = 4'(state_reg.burst_left - 4'h1);
    end
    if (dec.valid) begin
      unique case (dec.cmd)
        DCD_CMD_MRS: begin
          // Register control words and the dead register get no answer
          if ({pins.bg[0], pins.ba} != DCD_MR_RCW &&
              {pins.bg[0], pins.ba} != DCD_MR_SEVEN) begin
            state_next.mr_we     = 1'b1;
            state_next.mr_sel    = {pins.bg[0], pins.ba};
            state_next.mr_opcode = pins.addr;
            if ({pins.bg[0], pins.ba} == DCD_MR_ZERO) begin
              state_next.bl_mode = pins.addr[DCD_BL_HI:DCD_BL_LO];
            end
            if ({pins.bg[0], pins.ba} == DCD_MR_SIX) begin
              state_next.vref_train = pins.addr[DCD_VTRAIN_BIT];
              state_next.vref_load  = 1'b1;
              state_next.vref_value = pins.addr[6:0];
            end
          end
        end
        DCD_CMD_REF: state_next.refresh = 1'b1;
        DCD_CMD_WR, DCD_CMD_WRA, DCD_CMD_RD, DCD_CMD_RDA: begin
          // A new column command arriving during a running burst is dropped
          if (state_reg.burst_left == 4'h0) begin
            state_next.burst_left = dec.beats;
          end
        end
        DCD_CMD_ZQCL: state_next.zq_long  = 1'b1;
        DCD_CMD_ZQCS: state_next.zq_short = 1'b1;
        DCD_CMD_SRE:  state_next.pwr      = PWR_SELF;
        DCD_CMD_PDE:  state_next.pwr      = PWR_DOWN;
        DCD_CMD_SRX, DCD_CMD_PDX: state_next.pwr = PWR_ACTIVE;
        default: ;
      endcase
    end
    // Termination follows its pin except while self refreshing
    state_next.odt_active = pins.odt && (state_next.pwr != PWR_SELF);
    // Status levels get their own flops so no output is a decode of state
    state_next.burst_busy = (state_next.burst_left != 4'h0);
    state_next.in_self    = (state_next.pwr == PWR_SELF);
    state_next.in_pdn     = (state_next.pwr == PWR_DOWN);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg          <= '0;
      state_reg.pwr      <= PWR_ACTIVE;
      state_reg.dec.cmd  <= DCD_CMD_NONE;
      state_reg.bl_mode  <= DCD_BL_FIX8;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Refresh pulse is raised in power-down only by a REF after an illegal exit left the state there: only a command makes it
  assign o_dec          = state_reg.dec;
  assign o_mr_sel       = state_reg.mr_sel;
  assign o_mr_opcode    = state_reg.mr_opcode;
  assign o_mr_we        = state_reg.mr_we;
  assign o_bl_mode      = state_reg.bl_mode;
  assign o_burst_busy   = state_reg.burst_busy;
  assign o_zq_long      = state_reg.zq_long;
  assign o_zq_short     = state_reg.zq_short;
  assign o_refresh      = state_reg.refresh;
  assign o_self_refresh = state_reg.in_self;
  assign o_power_down   = state_reg.in_pdn;
  assign o_odt_active   = state_reg.odt_active;
  assign o_vref_train   = state_reg.vref_train;
  assign o_vref_range   = vref_range;
  assign o_vref_level   = vref_level;
endmodule

// [test/dcd_decoder_monitor.sv]
`timescale 1ns/10ps
module dcd_decoder_monitor (
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire dcd_pkg::dcd_pins_type i_pins,
  input  wire dcd_pkg::dcd_dec_type  o_dec,
  input  wire logic [2:0]            o_mr_sel,
  input  wire logic [13:0]           o_mr_opcode,
  input  wire logic                  o_mr_we,
  input  wire logic [1:0]            o_bl_mode,
  input  wire logic                  o_burst_busy,
  input  wire logic                  o_zq_long,
  input  wire logic                  o_zq_short,
  input  wire logic                  o_refresh,
  input  wire logic                  o_self_refresh,
  input  wire logic                  o_power_down,
  input  wire logic                  o_odt_active
);
  import dcd_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // Burst tracking
  // ----------------------------------------------------------------
  // Only a burst starting from idle is judged, a follower must not restart it
  logic rdwr;
  assign rdwr = o_dec.valid && (o_dec.cmd inside {DCD_CMD_RD, DCD_CMD_RDA, DCD_CMD_WR, DCD_CMD_WRA});
  sequence s_start4; rdwr && o_dec.beats == DCD_BEATS_BC4 && !$past(o_burst_busy); endsequence
  sequence s_start8; rdwr && o_dec.beats == DCD_BEATS_BL8 && !$past(o_burst_busy); endsequence
  property p_burst4; s_start4 |-> o_burst_busy [*4] ##1 !o_burst_busy; endproperty
  property p_burst8; s_start8 |-> o_burst_busy [*8] ##1 !o_burst_busy; endproperty
  property p_otf; (rdwr && o_bl_mode == DCD_BL_OTF) |->
    o_dec.beats == (o_dec.row[DCD_A12_BIT] ? DCD_BEATS_BL8 : DCD_BEATS_BC4); endproperty
  // ----------------------------------------------------------------
  // Command effects
  // ----------------------------------------------------------------
  property p_zql; o_zq_long == (o_dec.valid && o_dec.cmd == DCD_CMD_ZQCL && o_dec.row[DCD_A10_BIT]); endproperty
  property p_zqs; o_zq_short == (o_dec.valid && o_dec.cmd == DCD_CMD_ZQCS && !o_dec.row[DCD_A10_BIT]); endproperty
  property p_ref; o_refresh == (o_dec.valid && o_dec.cmd == DCD_CMD_REF && !o_power_down); endproperty
  property p_odt; o_self_refresh |-> !o_odt_active; endproperty
  property p_mr7; (o_dec.cmd == DCD_CMD_MRS && {o_dec.bg[0], o_dec.ba} == DCD_MR_SEVEN) |->
    !o_mr_we && o_mr_opcode == $past(o_mr_opcode); endproperty
  property p_mrw; o_mr_we |-> o_dec.cmd == DCD_CMD_MRS && o_mr_sel == {o_dec.bg[0], o_dec.ba} &&
    o_mr_opcode == o_dec.row[13:0]; endproperty
  property p_act; o_dec.cmd == DCD_CMD_ACT |-> o_dec.bg == $past(i_pins.bg, 3) &&
    o_dec.ba == $past(i_pins.ba, 3) &&
    o_dec.row == {$past(i_pins.ras_n, 3), $past(i_pins.cas_n, 3), $past(i_pins.we_n, 3),
                  $past(i_pins.addr, 3)}; endproperty
  property p_ill; o_dec.illegal |-> !o_dec.valid && !o_mr_we && !o_refresh && $stable(o_power_down); endproperty
  a_burst4: assert property (p_burst4) else $error("short chop burst cut");
  a_burst8: assert property (p_burst8) else $error("eight beat burst cut");
  a_otf: assert property (p_otf) else $error("on the fly length wrong");
  a_zql: assert property (p_zql) else $error("long calibration pulse wrong");
  a_zqs: assert property (p_zqs) else $error("short calibration pulse wrong");
  a_ref: assert property (p_ref) else $error("refresh pulse unexpected");
  a_odt: assert property (p_odt) else $error("termination active in self refresh");
  a_mr7: assert property (p_mr7) else $error("code seven write took effect");
  a_mrw: assert property (p_mrw) else $error("mode write target wrong");
  a_act: assert property (p_act) else $error("activate row or group wrong");
  a_ill: assert property (p_ill) else $error("illegal code changed state");
endmodule

bind dcd_decoder dcd_decoder_monitor u_mon (.*);

// [test/dcd_ctrl_model.sv]
`timescale 1ns/10ps
module dcd_ctrl_model (
  input  wire logic                  i_clock,
  input  wire dcd_pkg::dcd_pins_type i_cmd,
  output dcd_pkg::dcd_pins_type      o_pins
);
  import dcd_pkg::*;
  // ----------------------------------------------------------------
  // Command bus driver
  // ----------------------------------------------------------------
  // Lines launch on the edge only, so clock enable moves with a running clock
  // Deselected lines wobble each cycle so stale values never look valid
  logic alt = 1'b0;
  always @(posedge i_clock) begin
    alt <= ~alt;
    if (i_cmd.cs_n) begin
      o_pins <= {i_cmd.cs_n, {4{alt}}, i_cmd.cke, i_cmd.odt, {18{alt}}};
    end else begin
      o_pins <= i_cmd;
    end
  end
endmodule

// [test/tb_dram_command_decoder_vref.sv]
`timescale 1ns/10ps
module tb_dram_command_decoder_vref;
  import dcd_pkg::*;
  logic         clk = 1'b0;
  logic         srst;
  dcd_pins_type req, pins;
  dcd_dec_type  dec;
  logic [2:0]   mr_sel;
  logic [13:0]  mr_op, vlevel;
  logic [1:0]   bl_mode, bl = DCD_BL_FIX8;
  logic         mr_we, busy, zql, zqs, refr, sref, pdn, odt_act, vtrain, vrange;
  logic         odt_lvl = 1'b0, cke_lvl = 1'b1, etr = 1'b0, erg = 1'b0;
  logic [2:0]   esel;
  logic [13:0]  eop, exp_q[$], got_q[$];
  int           pc = 0, sr = 0, nwe = 0, awe = 0, elv = 6000, error_cnt = 0, n_compared = 0, v;
  int           bm[3] = '{1, 2, 0};

  initial begin
    forever #2.5 clk = ~clk;
  end

  dcd_ctrl_model u_ctrl (.i_clock(clk), .i_cmd(req), .o_pins(pins));
  dcd_decoder u_dut (.i_clock(clk), .i_srst(srst), .i_pins(pins), .o_dec(dec), .o_mr_sel(mr_sel),
    .o_mr_opcode(mr_op), .o_mr_we(mr_we), .o_bl_mode(bl_mode), .o_burst_busy(busy), .o_zq_long(zql),
    .o_zq_short(zqs), .o_refresh(refr), .o_self_refresh(sref), .o_power_down(pdn), .o_odt_active(odt_act),
    .o_vref_train(vtrain), .o_vref_range(vrange), .o_vref_level(vlevel));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic rw(dcd_cmd_type c);
    return c inside {DCD_CMD_RD, DCD_CMD_RDA, DCD_CMD_WR, DCD_CMD_WRA};
  endfunction
  function automatic logic bk(dcd_cmd_type c);
    return rw(c) || (c inside {DCD_CMD_MRS, DCD_CMD_ACT, DCD_CMD_PRE});
  endfunction
  // Bank fields only count where the command uses them
  function automatic logic [13:0] key(dcd_cmd_type c, logic il, logic [3:0] b, logic [1:0] g, logic [1:0] a);
    return {c, il, rw(c) ? b : 4'h0, bk(c) ? {g, a} : 4'h0};
  endfunction
  function automatic dcd_pins_type mk(logic [2:0] rcw, logic act_n, logic [13:0] a, logic ck);
    dcd_pins_type p;
    p = '0;
    {p.act_n, p.ras_n, p.cas_n, p.we_n} = {act_n, rcw};
    p.cke = ck;
    p.odt = odt_lvl | 1'($urandom);
    p.bg = 2'($urandom);
    p.ba = 2'($urandom);
    p.addr = a;
    return p;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference model and driver
  // ----------------------------------------------------------------
  // Decodes against the previous clock enable, then launches one command
  task automatic send(input dcd_pins_type p);
    dcd_cmd_type c;
    logic [3:0]  b;
    logic [2:0]  s;
    logic        nop;
    c = DCD_CMD_DES;
    s = {p.bg[0], p.ba};
    nop = !p.cs_n && p.act_n && {p.ras_n, p.cas_n, p.we_n} == 3'h7;
    // Clock enable held low is no command at all
    if (pc == 0) begin
      if (p.cke) c = (p.cs_n || nop) ? ((sr != 0) ? DCD_CMD_SRX : DCD_CMD_PDX) : DCD_CMD_ILLEGL;
    end else if (!p.cke) begin
      if (p.cs_n || nop) c = DCD_CMD_PDE;
      else c = (p.act_n && {p.ras_n, p.cas_n, p.we_n} == 3'h1) ? DCD_CMD_SRE : DCD_CMD_ILLEGL;
    end else if (p.cs_n) c = DCD_CMD_DES;
    else if (!p.act_n) c = DCD_CMD_ACT;
    else begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h0: c = DCD_CMD_MRS;
        3'h1: c = DCD_CMD_REF;
        3'h2: c = p.addr[DCD_A10_BIT] ? DCD_CMD_PREA : DCD_CMD_PRE;
        3'h3: c = DCD_CMD_ILLEGL;
        3'h4: c = p.addr[DCD_A10_BIT] ? DCD_CMD_WRA : DCD_CMD_WR;
        3'h5: c = p.addr[DCD_A10_BIT] ? DCD_CMD_RDA : DCD_CMD_RD;
        3'h6: c = p.addr[DCD_A10_BIT] ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
        default: c = DCD_CMD_NOP;
      endcase
    end
    sr = (c == DCD_CMD_SRE) ? 1 : (c == DCD_CMD_SRX) ? 0 : sr;
    if (c == DCD_CMD_MRS && s != DCD_MR_SEVEN) begin
      nwe++;
      esel = s;
      eop = p.addr;
      if (s == DCD_MR_ZERO) bl = p.addr[DCD_BL_HI:DCD_BL_LO];
      if (s == DCD_MR_SIX) begin
        {etr, erg} = p.addr[DCD_VTRAIN_BIT:DCD_VRANGE_BIT];
        elv = (erg ? 4500 : 6000) + ((p.addr[5:0] > 49) ? 49 : p.addr[5:0]) * 65;
      end
    end
    b = (bl == DCD_BL_OTF) ? (p.addr[DCD_A12_BIT] ? 4'h8 : 4'h4) : ((bl == DCD_BL_FIX4) ? 4'h4 : 4'h8);
    if (c != DCD_CMD_DES) exp_q.push_back(key(c, c == DCD_CMD_ILLEGL, b, p.bg, p.ba));
    pc = p.cke;
    @(posedge clk);
    req <= p;
  endtask
  task automatic idle(input int n);
    dcd_pins_type p;
    repeat (n) begin
      p = mk(3'h7, 1'b1, 14'h0000, cke_lvl);
      p.cs_n = 1'b1;
      send(p);
    end
  endtask
  task automatic mrs(input logic [2:0] sel, input logic bg1, input logic [13:0] op);
    dcd_pins_type p;
    p = mk(3'h0, 1'b1, op, 1'b1);
    {p.bg, p.ba} = {bg1, sel};
    send(p);
  endtask

  // Every decoded command except deselect is logged as seen by the design
  always @(posedge clk) begin
    if (!srst && (dec.valid === 1'b1 || dec.illegal === 1'b1) && dec.cmd !== DCD_CMD_DES)
      got_q.push_back(key(dec.cmd, dec.illegal, dec.beats, dec.bg, dec.ba));
    if (mr_we === 1'b1) awe++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    req.cs_n = 1'b1;
    req.cke = 1'b1;
    srst = 1'b1;
    void'($urandom(81));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    idle(2);
    // Each length mode with back-to-back reads and writes
    for (int m = 0; m < 3; m++) begin
      mrs(DCD_MR_ZERO, 1'b0, 14'(bm[m]));
      idle(4);
      for (int k = 0; k < 3; k++) send(mk({2'h2, 1'($urandom)}, 1'b1, 14'($urandom), 1'b1));
      idle(10);
    end
    // Command table except mode write and no-op, both A10 levels, plus activate
    for (int j = 0; j < 2; j++) begin
      for (int r = 1; r < 7; r++) send(mk(3'(r), 1'b1, {3'($urandom), 1'(j), 10'($urandom)}, 1'b1));
      send(mk(3'($urandom), 1'b0, 14'($urandom), 1'b1));
      idle(12);
    end
    // Ignored mode codes leave the last write in place
    mrs(DCD_MR_SEVEN, 1'b0, 14'($urandom));
    mrs(DCD_MR_SEVEN, 1'b1, 14'($urandom));
    idle(5);
    #1;
    chk(mr_sel, esel);
    chk(mr_op, eop);
    // Reference steps, training enabled while stepping
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 49 : $urandom_range(49, 0);
      mrs(DCD_MR_SIX, 1'b0, {6'h00, 1'b1, 1'($urandom), 6'(v)});
      idle(5);
      #1;
      chk(vlevel, 32'(elv));
      chk({vtrain, vrange}, {etr, erg});
    end
    // Self refresh with termination requested, then power down
    odt_lvl = 1'b1;
    idle(3);
    send(mk(3'h1, 1'b1, 14'h0000, 1'b0));
    cke_lvl = 1'b0;
    idle(6);
    #1;
    chk({sref, odt_act}, 2'h2);
    cke_lvl = 1'b1;
    idle(6);
    #1;
    chk({sref, odt_act, pdn}, 3'h2);
    cke_lvl = 1'b0;
    idle(6);
    #1;
    chk(pdn, 1'b1);
    cke_lvl = 1'b1;
    idle(6);
    #1;
    chk(pdn, 1'b0);
    chk(bl_mode, bl);
    chk(awe, nwe);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
    complete_run();
  end

  // Cuts a hang well beyond the roughly 155 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule
